// ### design/mief_pkg.sv
// constants shared by the interrupt enable and flag logic
package mief_pkg;
  // register indices; the byte address is four times the index
  localparam logic [9:0] MIEF_IDX_CORE_CTRL    = 10'h00B;
  localparam logic [9:0] MIEF_IDX_CORE_MIR1    = 10'h08B;
  localparam logic [9:0] MIEF_IDX_CORE_MIR2    = 10'h10B;
  localparam logic [9:0] MIEF_IDX_CORE_MIR3    = 10'h18B;
  localparam logic [9:0] MIEF_IDX_PERIPH_EN    = 10'h08C;
  localparam logic [9:0] MIEF_IDX_PERIPH_FLAG  = 10'h00C;
  localparam logic [9:0] MIEF_IDX_PORT_B       = 10'h006;
  localparam logic [9:0] MIEF_IDX_CFG          = 10'h040;
  localparam logic [9:0] MIEF_IDX_IRQ_STATUS   = 10'h041;
  localparam logic [9:0] MIEF_IDX_IRQ_MASK     = 10'h042;
  localparam int         MIEF_ADDR_W           = 12;
  localparam int         MIEF_IDX_LSB          = 2;

  // core control field positions
  localparam int MIEF_GIE_BIT  = 7;
  localparam int MIEF_PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int MIEF_T0IE_BIT = 5;
  localparam int MIEF_EXIE_BIT = 4;
  localparam int MIEF_PCIE_BIT = 3;
  localparam int MIEF_T0IF_BIT = 2;
  localparam int MIEF_EXIF_BIT = 1;
  localparam int MIEF_PCIF_BIT = 0;

  // peripheral source positions, shared by enable and flag registers
  localparam int MIEF_NPER      = 7;
  localparam int MIEF_ADC_BIT   = 6;
  localparam logic [6:0] MIEF_PIR_SW_WRITABLE = 7'h47;

  // sticky status layout
  localparam int MIEF_NSTS      = 4;
  localparam int MIEF_ST_T0     = 0;
  localparam int MIEF_ST_EXT    = 1;
  localparam int MIEF_ST_PORT   = 2;
  localparam int MIEF_ST_PER    = 3;

  // reset values
  localparam logic [7:0] MIEF_CORE_RST  = 8'h00;
  localparam logic [6:0] MIEF_PER_RST   = 7'h00;
  localparam logic [3:0] MIEF_NIB_RST   = 4'h0;
  localparam logic       MIEF_EDGE_RST  = 1'b1;
  localparam int         MIEF_CFG_EDGE_BIT = 0;
endpackage

// ### design/mief_irq_logic.sv
// interrupt enable and flag logic with an apb register slave
`timescale 1ns/1ps
module mief_irq_logic #(
  parameter bit HAS_CONVERTER = 1'b1
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [mief_pkg::MIEF_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                         pwdata,
  output logic [31:0]                              prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                timer_zero_overflow,
  input  wire logic                                external_interrupt_pin,
  input  wire logic [3:0]                          port_b_a_upper,
  input  wire logic [mief_pkg::MIEF_NPER-1:0]      periph_set,
  input  wire logic [mief_pkg::MIEF_NPER-1:0]      periph_level,
  output logic                                     core_irq_req,
  output logic                                     irq
);
  import mief_pkg::*;

  typedef struct packed {
    logic [7:0]      core;
    logic [6:0]      pie;
    logic [6:0]      pir;
    logic [3:0]      port_latch;
    logic            ext_s1;
    logic            ext_s2;
    logic            ext_prev;
    logic [2:0]      ext_live;
    logic [3:0]      pb_s1;
    logic [3:0]      pb_s2;
    logic            edge_rising;
    logic [3:0]      ists;
    logic [3:0]      imask;
    logic [31:0]     rdata;
    logic            slverr;
  } mief_state_t;

  mief_state_t st_q;
  mief_state_t st_d;

  // word index of an apb address
  function automatic logic [9:0] mief_idx(input logic [MIEF_ADDR_W-1:0] a);
    mief_idx = a[MIEF_ADDR_W-1:MIEF_IDX_LSB];
  endfunction

  // any of the four core control mirrors
  function automatic logic mief_is_core(input logic [9:0] i);
    mief_is_core = (i == MIEF_IDX_CORE_CTRL) || (i == MIEF_IDX_CORE_MIR1) ||
                   (i == MIEF_IDX_CORE_MIR2) || (i == MIEF_IDX_CORE_MIR3);
  endfunction

  // mask of implemented peripheral bits; converter bit may be missing
  localparam logic [6:0] PER_IMPL = HAS_CONVERTER ? 7'h7F : 7'h3F;

  logic [9:0]  idx;
  logic        setup_ph;
  logic        access_ph;
  logic        wr_core;
  logic        wr_pie;
  logic        wr_pir;
  logic        wr_cfg;
  logic        wr_ists;
  logic        wr_imask;
  logic        rd_port;
  logic        mapped;
  logic        ext_edge;
  logic        pb_mismatch;
  logic [6:0]  per_pending;
  logic [3:0]  ev;
  logic [31:0] rd_mux;

  // bus decode; the slave never stretches, so pready is tied high in access
  always_comb
  begin
    idx       = mief_idx(paddr);
    setup_ph  = psel && !penable;
    access_ph = psel && penable;
    mapped    = mief_is_core(idx) || (idx == MIEF_IDX_PERIPH_EN) ||
                (idx == MIEF_IDX_PERIPH_FLAG) || (idx == MIEF_IDX_PORT_B) ||
                (idx == MIEF_IDX_CFG) || (idx == MIEF_IDX_IRQ_STATUS) ||
                (idx == MIEF_IDX_IRQ_MASK);
    wr_core   = access_ph && pwrite && mief_is_core(idx);
    wr_pie    = access_ph && pwrite && (idx == MIEF_IDX_PERIPH_EN);
    wr_pir    = access_ph && pwrite && (idx == MIEF_IDX_PERIPH_FLAG);
    wr_cfg    = access_ph && pwrite && (idx == MIEF_IDX_CFG);
    wr_ists   = access_ph && pwrite && (idx == MIEF_IDX_IRQ_STATUS);
    wr_imask  = access_ph && pwrite && (idx == MIEF_IDX_IRQ_MASK);
    rd_port   = access_ph && !pwrite && (idx == MIEF_IDX_PORT_B);
  end

  // pin events use synchronised pins; timer and peripheral events are taken directly
  always_comb
  begin
    // blind until synchroniser and history hold real samples, so a pin
    // that idles high gives no false edge right after reset
    ext_edge    = st_q.ext_live[2] &&
                  (st_q.edge_rising ? (st_q.ext_s2 && !st_q.ext_prev)
                                    : (!st_q.ext_s2 && st_q.ext_prev));
    pb_mismatch = (st_q.pb_s2 != st_q.port_latch);
    ev[MIEF_ST_T0]   = timer_zero_overflow;
    ev[MIEF_ST_EXT]  = ext_edge;
    ev[MIEF_ST_PORT] = pb_mismatch;
    ev[MIEF_ST_PER]  = |(periph_set & PER_IMPL);
  end

  // read data, captured in the setup cycle so prdata comes from a flop
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (mief_is_core(idx))
      rd_mux[7:0] = st_q.core;
    else if (idx == MIEF_IDX_PERIPH_EN)
      rd_mux[6:0] = st_q.pie & PER_IMPL;
    else if (idx == MIEF_IDX_PERIPH_FLAG)
      rd_mux[6:0] = st_q.pir & PER_IMPL;
    else if (idx == MIEF_IDX_PORT_B)
      rd_mux[3:0] = st_q.pb_s2;
    else if (idx == MIEF_IDX_CFG)
      rd_mux[MIEF_CFG_EDGE_BIT] = st_q.edge_rising;
    else if (idx == MIEF_IDX_IRQ_STATUS)
      rd_mux[3:0] = st_q.ists;
    else if (idx == MIEF_IDX_IRQ_MASK)
      rd_mux[3:0] = st_q.imask;
  end

  // next state; in every flag a hardware set wins over a same-cycle clear
  always_comb
  begin
    st_d = st_q;
    st_d.ext_s1   = external_interrupt_pin;
    st_d.ext_s2   = st_q.ext_s1;
    st_d.ext_prev = st_q.ext_s2;
    st_d.ext_live = {st_q.ext_live[1:0], 1'b1};
    st_d.pb_s1    = port_b_a_upper;
    st_d.pb_s2    = st_q.pb_s1;
    if (wr_core)
      st_d.core = pwdata[7:0];
    // flags set independent of any enable
    if (timer_zero_overflow)
      st_d.core[MIEF_T0IF_BIT] = 1'b1;
    if (ext_edge)
      st_d.core[MIEF_EXIF_BIT] = 1'b1;
    // a live mismatch re-sets the flag, so a clear only sticks after a port read
    if (pb_mismatch)
      st_d.core[MIEF_PCIF_BIT] = 1'b1;
    if (rd_port)
      st_d.port_latch = st_q.pb_s2;
    if (wr_pie)
      st_d.pie = pwdata[6:0] & PER_IMPL;
    // writable flags from software, hardware-owned ones follow their source
    if (wr_pir)
      st_d.pir = (st_q.pir & ~MIEF_PIR_SW_WRITABLE) |
                 (pwdata[6:0] & MIEF_PIR_SW_WRITABLE);
    st_d.pir = ((st_d.pir & MIEF_PIR_SW_WRITABLE) |
                (periph_level & ~MIEF_PIR_SW_WRITABLE) | periph_set) & PER_IMPL;
    if (wr_cfg)
      st_d.edge_rising = pwdata[MIEF_CFG_EDGE_BIT];
    if (wr_imask)
      st_d.imask = pwdata[3:0];
    // write one to clear; a new event in that cycle keeps its bit
    st_d.ists = (wr_ists ? (st_q.ists & ~pwdata[3:0]) : st_q.ists) | ev;
    if (setup_ph)
    begin
      st_d.rdata  = pwrite ? 32'h0000_0000 : rd_mux;
      st_d.slverr = !mapped;
    end
  end

  // single register stage for all state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.edge_rising <= MIEF_EDGE_RST;
    end
    else
      st_q <= st_d;
  end

  // combined request toward the core
  always_comb
  begin
    per_pending  = st_q.pir & st_q.pie & PER_IMPL;
    core_irq_req = st_q.core[MIEF_GIE_BIT] && (
                   (st_q.core[MIEF_T0IF_BIT] && st_q.core[MIEF_T0IE_BIT]) ||
                   (st_q.core[MIEF_EXIF_BIT] && st_q.core[MIEF_EXIE_BIT]) ||
                   (st_q.core[MIEF_PCIF_BIT] && st_q.core[MIEF_PCIE_BIT]) ||
                   (st_q.core[MIEF_PERIPHERAL_GROUP_ENABLE_BIT] && (|per_pending)));
  end

  assign irq     = |(st_q.ists & st_q.imask);
  assign prdata  = st_q.rdata;
  assign pslverr = st_q.slverr && access_ph;
  assign pready  = 1'b1;

  // checks on the flags, the enables and the request
  property p_gie_blocks;
    @(posedge pclk) disable iff (!presetn)
      !st_q.core[MIEF_GIE_BIT] |-> !core_irq_req;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks)
    else $error("request with global enable clear");

  property p_peripheral_group_enable_gates;
    @(posedge pclk) disable iff (!presetn)
      (!st_q.core[MIEF_PERIPHERAL_GROUP_ENABLE_BIT] &&
       !(st_q.core[MIEF_T0IF_BIT] && st_q.core[MIEF_T0IE_BIT]) &&
       !(st_q.core[MIEF_EXIF_BIT] && st_q.core[MIEF_EXIE_BIT]) &&
       !(st_q.core[MIEF_PCIF_BIT] && st_q.core[MIEF_PCIE_BIT])) |-> !core_irq_req;
  endproperty
  a_peripheral_group_enable_gates: assert property (p_peripheral_group_enable_gates)
    else $error("peripheral request passed a clear group enable");

  property p_t0_request;
    @(posedge pclk) disable iff (!presetn)
      (st_q.core[MIEF_GIE_BIT] && st_q.core[MIEF_T0IE_BIT] &&
       st_q.core[MIEF_T0IF_BIT]) |-> core_irq_req;
  endproperty
  a_t0_request: assert property (p_t0_request)
    else $error("enabled timer flag gave no request");

  property p_t0_set;
    @(posedge pclk) disable iff (!presetn)
      timer_zero_overflow |=> st_q.core[MIEF_T0IF_BIT] && st_q.ists[MIEF_ST_T0];
  endproperty
  a_t0_set: assert property (p_t0_set)
    else $error("timer overflow did not set its flag");

  property p_t0_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_q.core[MIEF_T0IF_BIT] && !wr_core) |=> st_q.core[MIEF_T0IF_BIT];
  endproperty
  a_t0_hold: assert property (p_t0_hold)
    else $error("timer flag cleared without a write");

  property p_ext_request;
    @(posedge pclk) disable iff (!presetn)
      (st_q.core[MIEF_GIE_BIT] && st_q.core[MIEF_EXIE_BIT] &&
       st_q.core[MIEF_EXIF_BIT]) |-> core_irq_req;
  endproperty
  a_ext_request: assert property (p_ext_request)
    else $error("enabled pin flag gave no request");

  property p_ext_rise;
    @(posedge pclk) disable iff (!presetn)
      (st_q.edge_rising && !wr_cfg && $rose(external_interrupt_pin))
        |-> ##[3:4] st_q.core[MIEF_EXIF_BIT];
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("rising pin edge did not set the pin flag");

  property p_port_request;
    @(posedge pclk) disable iff (!presetn)
      (st_q.core[MIEF_GIE_BIT] && st_q.core[MIEF_PCIE_BIT] &&
       st_q.core[MIEF_PCIF_BIT]) |-> core_irq_req;
  endproperty
  a_port_request: assert property (p_port_request)
    else $error("enabled port flag gave no request");

  property p_mismatch_keeps;
    @(posedge pclk) disable iff (!presetn)
      pb_mismatch |=> st_q.core[MIEF_PCIF_BIT];
  endproperty
  a_mismatch_keeps: assert property (p_mismatch_keeps)
    else $error("mismatch did not keep the port flag set");

  property p_port_read_ends;
    @(posedge pclk) disable iff (!presetn)
      rd_port |=> (st_q.port_latch == $past(st_q.pb_s2));
  endproperty
  a_port_read_ends: assert property (p_port_read_ends)
    else $error("port read did not load the mismatch latch");

  property p_mirror_same;
    @(posedge pclk) disable iff (!presetn)
      wr_core |=> (st_q.core[MIEF_GIE_BIT] == $past(pwdata[MIEF_GIE_BIT])) &&
                  (st_q.core[MIEF_PCIE_BIT] == $past(pwdata[MIEF_PCIE_BIT]));
  endproperty
  a_mirror_same: assert property (p_mirror_same)
    else $error("core control write lost at a mirror");

  property p_pie_top_zero;
    @(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && (idx == MIEF_IDX_PERIPH_EN)) |=> (prdata[31:7] == 25'h0);
  endproperty
  a_pie_top_zero: assert property (p_pie_top_zero)
    else $error("peripheral enable upper bits not zero");

  property p_no_converter;
    @(posedge pclk) disable iff (!presetn)
      !HAS_CONVERTER |-> !st_q.pie[MIEF_ADC_BIT] && !st_q.pir[MIEF_ADC_BIT];
  endproperty
  a_no_converter: assert property (p_no_converter)
    else $error("converter bit present on a variant without it");

  property p_per_set;
    @(posedge pclk) disable iff (!presetn)
      (periph_set[0] && !wr_pir) |=> st_q.pir[0] ##1 (st_q.pir[0] || $past(wr_pir));
  endproperty
  a_per_set: assert property (p_per_set)
    else $error("peripheral event did not set its flag");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      ((|(ev & st_q.imask)) && !wr_imask) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with status and mask");

  property p_ext_fall;
    @(posedge pclk) disable iff (!presetn)
      (!st_q.edge_rising && !wr_cfg && $fell(external_interrupt_pin))
        |-> ##[3:4] st_q.core[MIEF_EXIF_BIT];
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("falling pin edge did not set the pin flag");

  property p_ext_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_q.core[MIEF_EXIF_BIT] && !wr_core) |=> st_q.core[MIEF_EXIF_BIT];
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("pin flag cleared without a write");

  property p_peripheral_group_enable_pass;
    @(posedge pclk) disable iff (!presetn)
      (st_q.core[MIEF_GIE_BIT] && st_q.core[MIEF_PERIPHERAL_GROUP_ENABLE_BIT] &&
       (|(st_q.pir & st_q.pie))) |-> core_irq_req;
  endproperty
  a_peripheral_group_enable_pass: assert property (p_peripheral_group_enable_pass)
    else $error("enabled peripheral flag gave no request");

  property p_pie_write;
    @(posedge pclk) disable iff (!presetn)
      wr_pie |=> (st_q.pie[MIEF_ADC_BIT-1:0] == $past(pwdata[MIEF_ADC_BIT-1:0]));
  endproperty
  a_pie_write: assert property (p_pie_write)
    else $error("peripheral enable write not stored at its positions");

  property p_enables_hold;
    @(posedge pclk) disable iff (!presetn)
      !wr_core |=> $stable(st_q.core[MIEF_GIE_BIT:MIEF_PCIE_BIT]);
  endproperty
  a_enables_hold: assert property (p_enables_hold)
    else $error("core enable changed without a write");

  property p_status_sticky;
    @(posedge pclk) disable iff (!presetn)
      (st_q.ists[MIEF_ST_T0] && !wr_ists) |=> st_q.ists[MIEF_ST_T0];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("timer status bit dropped without a clear");
endmodule

// ### verification/mief_core_model.sv
// model of the processor core that takes the combined interrupt request
`timescale 1ns/1ps
module mief_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       core_irq_req,
  output logic [7:0]      taken_cnt_q
);
  logic req_q;
  // a held level counts once; the core takes one request per rising level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q       <= 1'b0;
      taken_cnt_q <= 8'h00;
    end
    else
    begin
      req_q <= core_irq_req;
      if (core_irq_req && !req_q)
        taken_cnt_q <= taken_cnt_q + 8'h01;
    end
  end
endmodule

// ### verification/mief_irq_logic_tb.sv
// self-checking bench for the interrupt enable and flag logic
`timescale 1ns/1ps
module mief_irq_logic_tb;
  typedef struct {
    logic [11:0] a;
    logic [31:0] w;
    logic [11:0] ra;
    logic [31:0] exp;
    logic        err;
  } mief_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] nc_prdata;
  logic        tzo, ext_pin, core_irq_req, irq;
  logic [3:0]  port_nib;
  logic [6:0]  pset, plevel;
  logic [7:0]  taken;
  logic [31:0] rdv;
  logic        rerr;
  int          fails, checks_done;
  // write address, write data, read-back address, expected word, expected refusal
  mief_row_t rows [5] = '{
    '{12'h02C, 32'h38, 12'h42C, 32'h38, 1'b0},
    '{12'h62C, 32'h18, 12'h22C, 32'h18, 1'b0},
    '{12'h230, 32'hFF, 12'h230, 32'h7F, 1'b0},
    '{12'h108, 32'h0F, 12'h108, 32'h0F, 1'b0},
    '{12'h3FC, 32'hFF, 12'h3FC, 32'h00, 1'b1}};

  mief_irq_logic dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_zero_overflow(tzo), .external_interrupt_pin(ext_pin),
    .port_b_a_upper(port_nib), .periph_set(pset), .periph_level(plevel),
    .core_irq_req(core_irq_req), .irq(irq));
  mief_core_model core_u (.pclk(pclk), .presetn(presetn), .core_irq_req(core_irq_req),
    .taken_cnt_q(taken));
  // variant without the converter on the same bus, read back beside the main one
  mief_irq_logic #(.HAS_CONVERTER(1'b0)) dut_nc_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(nc_prdata), .pready(), .pslverr(), .timer_zero_overflow(tzo),
    .external_interrupt_pin(ext_pin), .port_b_a_upper(port_nib), .periph_set(pset),
    .periph_level(plevel), .core_irq_req(), .irq());

  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  // one apb transfer; the request holds until pready is seen high at an edge or 20 edges pass
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      fails++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, rerr);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdv, rerr);
    chk(nm, exp, rdv);
  endtask

  // outputs are combinational from registers, so look mid-cycle
  task automatic req_is(input logic e);
    @(negedge pclk);
    chk("core_irq_req", {31'h0, e}, {31'h0, core_irq_req});
  endtask

  task automatic irq_is(input logic e);
    @(negedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic pulse_tzo();
    @(posedge pclk);
    tzo <= 1'b1;
    @(posedge pclk);
    tzo <= 1'b0;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // watchdog sized well above the few hundred cycles the tests take
  initial
  begin
    #(20 * 5000);
    fails++;
    summarize();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, tzo, ext_pin} = 6'h00;
    {paddr, pwdata, port_nib, pset, plevel} = '0;
    fails = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk("core_rst", 12'h02C, 32'h00);
    rchk("pie_rst", 12'h230, 32'h00);
    req_is(1'b0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rchk("row_read", rows[i].ra, rows[i].exp);
      chk("row_err", {31'h0, rows[i].err}, {31'h0, rerr});
    end
    rchk("pie_all", 12'h230, 32'h7F);
    chk("pie_nc", 32'h3F, nc_prdata);
    wr(12'h02C, 32'h00);
    pulse_tzo();
    rchk("t0_flag", 12'h02C, 32'h04);
    req_is(1'b0);
    wr(12'h02C, 32'hA4);
    req_is(1'b1);
    wr(12'h02C, 32'h84);
    req_is(1'b0);
    wr(12'h02C, 32'h80);
    rchk("t0_clr", 12'h02C, 32'h80);
    @(posedge pclk);
    ext_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk("pin_flag", 12'h02C, 32'h82);
    wr(12'h02C, 32'h92);
    req_is(1'b1);
    wr(12'h02C, 32'h12);
    req_is(1'b0);
    wr(12'h02C, 32'h80);
    rchk("pin_clr", 12'h02C, 32'h80);
    wr(12'h100, 32'h00);
    @(posedge pclk);
    ext_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    rchk("pin_fall", 12'h02C, 32'h82);
    wr(12'h02C, 32'h80);
    @(posedge pclk);
    port_nib <= 4'hA;
    repeat (4) @(posedge pclk);
    rchk("port_flag", 12'h02C, 32'h81);
    wr(12'h02C, 32'h80);
    rchk("port_stuck", 12'h02C, 32'h81);
    rchk("port_read", 12'h018, 32'h0A);
    wr(12'h02C, 32'h80);
    rchk("port_clr", 12'h02C, 32'h80);
    @(posedge pclk);
    pset   <= 7'h41;
    plevel <= 7'h08;
    @(posedge pclk);
    pset <= 7'h00;
    rchk("pir", 12'h030, 32'h49);
    chk("pir_nc", 32'h09, nc_prdata);
    req_is(1'b0);
    wr(12'h02C, 32'hC0);
    req_is(1'b1);
    wr(12'h02C, 32'h80);
    rchk("status", 12'h104, 32'h0F);
    irq_is(1'b1);
    wr(12'h108, 32'h00);
    irq_is(1'b0);
    wr(12'h104, 32'h0F);
    wr(12'h108, 32'h0F);
    rchk("status_clr", 12'h104, 32'h00);
    irq_is(1'b0);
    chk("core_takes", 32'h03, {24'h0, taken});
    // reset mid-run with a flag and enables set and the pin held high
    wr(12'h02C, 32'hA4);
    @(posedge pclk);
    presetn  <= 1'b0;
    port_nib <= 4'h0;
    ext_pin  <= 1'b1;
    @(posedge pclk);
    req_is(1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk("core_rst2", 12'h02C, 32'h00);
    rchk("pie_rst2", 12'h230, 32'h00);
    summarize();
  end
endmodule
